// >>> addr_space_pkg.sv
// Purpose: Shared constants for the core address space and stack block.
// Assumes: 12-bit program bus, 8-bit register bus, single register page.
// Notes: All map boundaries and option byte addresses live here by name.
package addr_space_pkg;
    localparam int PADDR_W = 12;
    localparam int RADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [11:0] PROG_TOP = 12'hFFF;
    localparam logic [11:0] VEC_HI_ADDR = 12'h000;
    localparam logic [11:0] VEC_LO_ADDR = 12'h001;
    localparam logic [11:0] RESET_ADDR = 12'h100;
    localparam logic [11:0] OPT_LVR_ADDR = 12'h03E;
    localparam logic [11:0] OPT_OSC_ADDR = 12'h03F;
    localparam logic [7:0] OPT_ERASED = 8'hFF;
    localparam logic [7:0] GP_TOP = 8'hBF;
    localparam logic [7:0] WREG_BASE = 8'hC0;
    localparam logic [7:0] WREG_TOP = 8'hCF;
    localparam logic [7:0] SP_ADDR = 8'hD9;
    localparam logic [7:0] SP_ADDR_NEXT = 8'h01;
    localparam logic [11:0] PC_ONE = 12'h001;
    // Operand locator modes, one-hot.
    typedef enum logic [5:0] {
        MODE_REG = 6'h01,
        indirect_register_mode = 6'h02,
        MODE_INDEXED = 6'h04,
        direct_address_mode = 6'h08,
        relative_address_mode = 6'h10,
        immediate_mode = 6'h20
    } opmode_t;
    // Stack sequencer states, one-hot.
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_PUSH_LO = 6'h02,
        ST_PUSH_HI = 6'h04,
        ST_PUSH_FL = 6'h08,
        ST_POP_FL = 6'h10,
        ST_POP_HI = 6'h20
    } stk_state_t;
endpackage : addr_space_pkg

// >>> operand_locator.sv
// Purpose: Forms the effective address of an operand for each addressing mode.
// Assumes: Register contents for indirect forms are supplied by the caller.
// Notes: Purely combinational; the main block drives its result straight to its outputs.
`timescale 1ns/10ps
module operand_locator (
    input wire addr_space_pkg::opmode_t mode,
    input wire logic working_sel,
    input wire logic [7:0] operand,
    input wire logic [7:0] reg_value,
    input wire logic [15:0] pair_value,
    output logic [7:0] reg_addr,
    output logic [15:0] mem_addr,
    output logic is_reg,
    output logic is_imm
);
    import addr_space_pkg::*;
    always_comb begin
        reg_addr = operand;
        mem_addr = pair_value;
        is_reg = 1'b1;
        is_imm = 1'b0;
        case (mode)
            MODE_REG: begin
                reg_addr = working_sel ? {WREG_BASE[7:4], operand[3:0]} : operand;
            end
            indirect_register_mode: begin
                reg_addr = reg_value;
                is_reg = working_sel;
            end
            MODE_INDEXED: begin
                reg_addr = operand + reg_value;
            end
            direct_address_mode: begin
                is_reg = 1'b0;
            end
            relative_address_mode: begin
                is_reg = 1'b0;
            end
            immediate_mode: begin
                is_reg = 1'b0;
                is_imm = 1'b1;
            end
            default: begin
                is_reg = 1'b1;
            end
        endcase
    end
endmodule : operand_locator

// >>> addr_space_core.sv
// Purpose: Program map, register file, stack pointer and operand locator.
// Assumes: The core sequences instructions and issues one command at a time.
// Notes: Register bus is 8 bits wide; stack lives in the register file.
`timescale 1ns/10ps
module addr_space_core (
    input wire logic clock,
    input wire logic resetn,
    // Program bus.
    output logic [addr_space_pkg::PADDR_W-1:0] prog_addr,
    input wire logic [7:0] prog_rdata,
    // Instruction pointer control.
    input wire logic ip_inc,
    input wire logic ip_load,
    input wire logic [11:0] ip_load_value,
    input wire logic vector_fetch,
    // Register bus.
    input wire logic reg_wr,
    input wire logic [addr_space_pkg::RADDR_W-1:0] reg_addr,
    input wire logic [addr_space_pkg::DATA_W-1:0] reg_wdata,
    output logic [addr_space_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [3:0] pair_sel,
    output logic [15:0] pair_rdata,
    // Stack commands.
    input wire logic call_req,
    input wire logic ret_req,
    input wire logic intr_ack,
    input wire logic intr_ret_req,
    input wire logic [7:0] flags_in,
    output logic [7:0] flags_out,
    output logic flags_restore,
    output logic stack_busy,
    output logic [11:0] instruction_pointer,
    output logic [7:0] stack_top_pointer,
    // Boot options.
    output logic low_voltage_reset,
    output logic rc_osc_sel,
    output logic [7:0] opt_lvr_byte,
    output logic [7:0] opt_osc_byte,
    output logic opt_valid,
    // Operand locator.
    input wire addr_space_pkg::opmode_t op_mode,
    input wire logic op_working,
    input wire logic [7:0] op_field,
    output logic [7:0] op_reg_addr,
    output logic [15:0] op_mem_addr,
    output logic op_is_reg,
    output logic op_is_imm
);
    import addr_space_pkg::*;

    localparam int GP_DEPTH = 256;

    logic [7:0] regs_r [GP_DEPTH];
    logic [7:0] sp_r;
    logic [11:0] ip_r;
    stk_state_t st_r;
    logic [1:0] opt_cnt_r;
    logic [7:0] opt_lvr_r;
    logic [7:0] opt_osc_r;
    logic [7:0] rd_r;
    logic [15:0] pair_r;
    logic [7:0] flags_r;
    logic flags_restore_r;
    logic [7:0] sp_dec;
    logic [7:0] sp_inc;
    logic ret_kind_r;
    logic [7:0] loc_reg_addr;
    logic [15:0] loc_mem_addr;
    logic [7:0] ind_value;

    assign sp_dec = sp_r - SP_ADDR_NEXT;
    assign sp_inc = sp_r + SP_ADDR_NEXT;

    always_comb begin
        if (!opt_valid) begin
            prog_addr = opt_cnt_r[0] ? OPT_OSC_ADDR : OPT_LVR_ADDR;
        end else if (vector_fetch) begin
            prog_addr = ip_r[0] ? VEC_LO_ADDR : VEC_HI_ADDR;
        end else begin
            prog_addr = ip_r & PROG_TOP;
        end
    end

    // Boot options are read over two cycles after reset release, before the core runs.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            opt_cnt_r <= 2'h0;
            opt_lvr_r <= OPT_ERASED;
            opt_osc_r <= OPT_ERASED;
        end else if (opt_cnt_r != 2'h2) begin
            opt_cnt_r <= opt_cnt_r + 2'h1;
            if (opt_cnt_r[0]) begin
                opt_osc_r <= prog_rdata;
            end else begin
                opt_lvr_r <= prog_rdata;
            end
        end
    end
    assign opt_valid = (opt_cnt_r == 2'h2);
    assign opt_lvr_byte = opt_lvr_r;
    assign opt_osc_byte = opt_osc_r;
    assign low_voltage_reset = (opt_lvr_r == OPT_ERASED) | opt_lvr_r[7];
    assign rc_osc_sel = (opt_osc_r == OPT_ERASED) | (opt_osc_r[1:0] != 2'h0);

    // return restores pointer
    // The high byte sits on top of the stack, so it comes back first and the low byte last.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ip_r <= RESET_ADDR;
        end else if (st_r == ST_POP_HI) begin
            ip_r <= {ip_r[11:8], regs_r[sp_r]};
        end else if (st_r == ST_POP_FL) begin
            ip_r <= {regs_r[sp_r][3:0], ip_r[7:0]};
        end else if (st_r == ST_IDLE && ret_req && !intr_ret_req && !call_req && !intr_ack) begin
            ip_r <= {regs_r[sp_r][3:0], ip_r[7:0]};
        end else if (ip_load) begin
            ip_r <= ip_load_value;
        end else if (ip_inc) begin
            ip_r <= ip_r + PC_ONE;
        end
    end
    assign instruction_pointer = ip_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_r <= ST_IDLE;
            ret_kind_r <= 1'b0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    if (intr_ack || call_req) begin
                        st_r <= ST_PUSH_LO;
                        ret_kind_r <= intr_ack;
                    end else if (intr_ret_req) begin
                        st_r <= ST_POP_FL;
                    end else if (ret_req) begin
                        st_r <= ST_POP_HI;
                    end
                end
                ST_PUSH_LO: st_r <= ST_PUSH_HI;
                ST_PUSH_HI: st_r <= ret_kind_r ? ST_PUSH_FL : ST_IDLE;
                ST_PUSH_FL: st_r <= ST_IDLE;
                ST_POP_FL: st_r <= ST_POP_HI;
                ST_POP_HI: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    assign stack_busy = (st_r != ST_IDLE);

    always_ff @(posedge clock) begin
        if (st_r == ST_PUSH_LO || st_r == ST_PUSH_HI || st_r == ST_PUSH_FL) begin
            sp_r <= sp_dec;
        end else if (st_r == ST_POP_FL || st_r == ST_POP_HI) begin
            sp_r <= sp_inc;
        end else if (st_r == ST_IDLE && (ret_req || intr_ret_req) && !call_req && !intr_ack) begin
            sp_r <= sp_inc;
        end else if (reg_wr && reg_addr == SP_ADDR) begin
            sp_r <= reg_wdata;
        end
    end
    assign stack_top_pointer = sp_r;

    always_ff @(posedge clock) begin
        case (st_r)
            ST_PUSH_LO: regs_r[sp_dec] <= ip_r[7:0];
            ST_PUSH_HI: regs_r[sp_dec] <= {4'h0, ip_r[11:8]};
            ST_PUSH_FL: regs_r[sp_dec] <= flags_in;
            default: begin
                if (reg_wr && reg_addr != SP_ADDR) begin
                    regs_r[reg_addr] <= reg_wdata;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flags_r <= 8'h00;
            flags_restore_r <= 1'b0;
        end else begin
            // Flags are the last byte pushed, so they are popped in the accepting cycle.
            flags_restore_r <= (st_r == ST_IDLE && intr_ret_req && !call_req && !intr_ack);
            if (st_r == ST_IDLE && intr_ret_req && !call_req && !intr_ack) begin
                flags_r <= regs_r[sp_r];
            end
        end
    end
    assign flags_out = flags_r;
    assign flags_restore = flags_restore_r;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_r <= 8'h00;
            pair_r <= 16'h0000;
        end else begin
            rd_r <= (reg_addr == SP_ADDR) ? sp_r : regs_r[reg_addr];
            pair_r <= {regs_r[{WREG_BASE[7:4], pair_sel[3:1], 1'b0}],
                       regs_r[{WREG_BASE[7:4], pair_sel[3:1], 1'b1}]};
        end
    end
    assign reg_rdata = rd_r;
    assign pair_rdata = pair_r;

    assign ind_value = regs_r[op_working ? {WREG_BASE[7:4], op_field[3:0]} : op_field];

    operand_locator u_loc (
        .mode(op_mode),
        .working_sel(op_working),
        .operand(op_field),
        .reg_value(ind_value),
        .pair_value(pair_r),
        .reg_addr(loc_reg_addr),
        .mem_addr(loc_mem_addr),
        .is_reg(op_is_reg),
        .is_imm(op_is_imm)
    );
    assign op_reg_addr = loc_reg_addr;
    assign op_mem_addr = loc_mem_addr;

    reset_ip_a: assert property (@(posedge clock) $rose(resetn) |-> ip_r == RESET_ADDR)
        else $error("pointer not at reset address");
    call_push_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_r == ST_IDLE && call_req && !intr_ack) |=> st_r == ST_PUSH_LO ##1 st_r == ST_PUSH_HI
        ##1 st_r == ST_IDLE)
        else $error("call push sequence wrong");
    intr_push_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_r == ST_IDLE && intr_ack) |=> ##2 st_r == ST_PUSH_FL)
        else $error("flags not pushed");
    sp_push_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_r == ST_PUSH_LO) |=> sp_r == $past(sp_r) - 8'h01)
        else $error("push did not decrement");
    sp_wrap_a: assert property (@(posedge clock) disable iff (!resetn)
        (st_r == ST_PUSH_LO && sp_r == 8'h00) |=> sp_r == 8'hFF)
        else $error("pointer did not wrap");
    opt_load_a: assert property (@(posedge clock) $rose(resetn) |-> ##2 opt_valid)
        else $error("options not loaded");
    vec_addr_a: assert property (@(posedge clock) disable iff (!resetn)
        (opt_valid && vector_fetch) |-> prog_addr[11:1] == 11'h000)
        else $error("vector address wrong");
    opt_def_a: assert property (@(posedge clock) disable iff (!resetn)
        (opt_valid && opt_lvr_r == 8'hFF && opt_osc_r == 8'hFF) |-> low_voltage_reset && rc_osc_sel)
        else $error("erased default wrong");
endmodule : addr_space_core

// >>> prog_rom_model.sv
// Purpose: Program memory image answering the core's program bus.
// Assumes: A read answers in the same cycle as its address.
// Notes: Option bytes are inputs so a test can change them between resets.
`timescale 1ns/10ps
module prog_rom_model (
    input wire logic [11:0] prog_addr,
    input wire logic [7:0] lvr_opt,
    input wire logic [7:0] osc_opt,
    output logic [7:0] prog_rdata
);
    always_comb begin
        case (prog_addr)
            12'h03C, 12'h03D: prog_rdata = 8'h00;
            12'h03E: prog_rdata = lvr_opt;
            12'h03F: prog_rdata = osc_opt;
            // A pattern that differs between neighbours exposes address slips.
            default: prog_rdata = prog_addr[7:0] ^ {prog_addr[11:8], 4'h5};
        endcase
    end
endmodule : prog_rom_model

// >>> cpu_address_space_and_stack_tb.sv
// Purpose: Self-checking bench for the address space and stack block.
// Assumes: One stack command at a time, issued only while the stack is idle.
// Notes: Expected values queue up; a monitor compares each against the outputs.
`timescale 1ns/10ps
module cpu_address_space_and_stack_tb;
    import addr_space_pkg::*;
    logic clock = 1'b0;
    logic resetn, ip_inc, ip_load, vector_fetch, reg_wr, call_req, ret_req;
    logic intr_ack, intr_ret_req, op_working, flags_restore, stack_busy;
    logic low_voltage_reset, rc_osc_sel, opt_valid, op_is_reg, op_is_imm;
    logic [11:0] ip_load_value, prog_addr, instruction_pointer;
    logic [7:0] prog_rdata, reg_addr, reg_wdata, reg_rdata, flags_in, flags_out;
    logic [7:0] stack_top_pointer, opt_lvr_byte, opt_osc_byte, op_field, op_reg_addr;
    logic [7:0] lvr_opt, osc_opt, a, d, fl;
    logic [3:0] pair_sel;
    logic [15:0] pair_rdata, op_mem_addr;
    opmode_t op_mode;
    int n_fail, check_count, seed, fr, i;
    logic [3:0] sel_q[$];
    logic [15:0] exp_q[$];
    event smp;

    always #25 clock = ~clock;

    addr_space_core DUT (.clock, .resetn, .prog_addr, .prog_rdata, .ip_inc, .ip_load,
        .ip_load_value, .vector_fetch, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
        .pair_sel, .pair_rdata, .call_req, .ret_req, .intr_ack, .intr_ret_req, .flags_in,
        .flags_out, .flags_restore, .stack_busy, .instruction_pointer, .stack_top_pointer,
        .low_voltage_reset, .rc_osc_sel, .opt_lvr_byte, .opt_osc_byte, .opt_valid,
        .op_mode, .op_working, .op_field, .op_reg_addr, .op_mem_addr, .op_is_reg, .op_is_imm);

    prog_rom_model rom (.prog_addr, .lvr_opt, .osc_opt, .prog_rdata);

    function automatic logic [15:0] got(input logic [3:0] s);
        case (s)
            0: got = {4'h0, instruction_pointer};
            1: got = {8'h00, stack_top_pointer};
            2: got = {8'h00, reg_rdata};
            3: got = pair_rdata;
            4: got = {8'h00, flags_out};
            5: got = {4'h0, prog_addr};
            6: got = {8'h00, op_reg_addr};
            7: got = {13'h0000, low_voltage_reset, rc_osc_sel, opt_valid};
            8: got = {14'h0000, op_is_reg, op_is_imm};
            9: got = {opt_lvr_byte, opt_osc_byte};
            10: got = {15'h0000, op_is_imm};
            default: got = 16'(fr);
        endcase
    endfunction : got

    always @(smp) begin
        while (sel_q.size() > 0) begin
            check_count++;
            if (got(sel_q[0]) !== exp_q[0]) begin
                n_fail++;
                $display("CHECK FAILED t=%0t sel=%0d got=%h exp=%h", $time, sel_q[0],
                    got(sel_q[0]), exp_q[0]);
            end
            void'(sel_q.pop_front());
            void'(exp_q.pop_front());
        end
    end

    task ex(input logic [3:0] s, input logic [15:0] e);
        sel_q.push_back(s);
        exp_q.push_back(e);
        ->smp;
        #1;
    endtask : ex

    task rst;
        resetn <= 1'b0;
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        // Option bytes are fetched on the first two edges after release.
        repeat (3) @(posedge clock);
        @(negedge clock);
    endtask : rst

    task wr(input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= ad;
        reg_wdata <= dt;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] ad, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= ad;
        @(posedge clock);
        @(negedge clock);
        ex(2, {8'h00, e});
    endtask : rd

    task ipld(input logic [11:0] v);
        @(posedge clock);
        ip_load <= 1'b1;
        ip_load_value <= v;
        @(posedge clock);
        ip_load <= 1'b0;
        @(negedge clock);
    endtask : ipld

    // Kinds: 0 call, 1 return, 2 interrupt, 3 interrupt return.
    task stk(input int k);
        int j;
        @(posedge clock);
        call_req <= (k == 0);
        ret_req <= (k == 1);
        intr_ack <= (k == 2);
        intr_ret_req <= (k == 3);
        flags_in <= fl;
        @(posedge clock);
        {call_req, ret_req, intr_ack, intr_ret_req} <= 4'h0;
        fr = 0;
        for (j = 0; j < 10; j++) begin
            @(negedge clock);
            if (flags_restore === 1'b1) fr++;
            if (stack_busy === 1'b0) break;
        end
        @(negedge clock);
        if (flags_restore === 1'b1) fr++;
    endtask : stk

    task tally_and_finish;
        $display("checks %0d failures %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (4000) @(posedge clock);
        n_fail++;
        tally_and_finish;
    end

    initial begin
        seed = 83;
        {ip_inc, ip_load, vector_fetch, reg_wr, call_req, ret_req} = 6'h00;
        {intr_ack, intr_ret_req, op_working} = 3'h0;
        ip_load_value = 12'h000;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        flags_in = 8'h00;
        fl = 8'h00;
        pair_sel = 4'h0;
        op_field = 8'h00;
        op_mode = MODE_REG;
        lvr_opt = 8'hFF;
        osc_opt = 8'hFF;
        rst;
        ex(0, 16'h0100);
        ex(5, 16'h0100);
        ex(7, 16'h0007);
        $display("reset test done");
        ipld(12'hFFE);
        ex(5, 16'h0FFE);
        @(posedge clock) vector_fetch <= 1'b1;
        @(negedge clock) ex(5, 16'h0000);
        @(posedge clock) {vector_fetch, ip_inc} <= 2'b01;
        @(posedge clock) {vector_fetch, ip_inc} <= 2'b10;
        @(negedge clock) ex(5, 16'h0001);
        ex(0, 16'h0FFF);
        @(posedge clock) vector_fetch <= 1'b0;
        $display("program map test done");
        wr(SP_ADDR, 8'hC0);
        rd(SP_ADDR, 8'hC0);
        ex(1, 16'h00C0);
        repeat (4) begin
            a = 8'($unsigned($random(seed)) % 192);
            d = 8'($random(seed));
            wr(a, d);
            rd(a, d);
        end
        wr(8'hC4, 8'h3A);
        wr(8'hC5, 8'h7E);
        @(posedge clock) pair_sel <= 4'h5;
        @(posedge clock);
        @(negedge clock) ex(3, 16'h3A7E);
        $display("register test done");
        ipld(12'h5A3);
        stk(0);
        ex(1, 16'h00BE);
        rd(8'hBF, 8'hA3);
        rd(8'hBE, 8'h05);
        ipld(12'h123);
        stk(1);
        ex(0, 16'h05A3);
        ex(1, 16'h00C0);
        fl = 8'($random(seed));
        ipld(12'h3C7);
        stk(2);
        ex(1, 16'h00BD);
        rd(8'hBD, fl);
        stk(3);
        ex(4, {8'h00, fl});
        ex(11, 16'h0001);
        ex(0, 16'h03C7);
        ex(1, 16'h00C0);
        wr(SP_ADDR, 8'h00);
        stk(0);
        ex(1, 16'h00FE);
        stk(1);
        ex(1, 16'h0000);
        $display("stack test done");
        for (i = 0; i < 6; i++) begin
            @(posedge clock);
            op_mode <= opmode_t'(6'h01 << i);
            op_working <= 1'b1;
            op_field <= 8'($random(seed));
            @(negedge clock);
            ex(10, {15'h0000, i == 5});
            if (i == 0) ex(6, {8'h00, 4'hC, op_field[3:0]});
            if (i == 0) ex(8, 16'h0002);
        end
        $display("operand test done");
        @(posedge clock);
        lvr_opt <= 8'h00;
        osc_opt <= 8'h00;
        rst;
        ex(9, 16'h0000);
        ex(7, 16'h0001);
        ex(0, 16'h0100);
        $display("option test done");
        tally_and_finish;
    end
endmodule : cpu_address_space_and_stack_tb
